// ### logic/cgm_ctrl.sv
// glyph ram addressing, display row fetch and reset state of the controller
// How it works
// - character code bits 0-3 become glyph ram address bits 3-6
// - glyph ram address bits 0-2 pick the pattern row
// - eighth row is the cursor row, shown as data ored with cursor
// - glyph ram data bits 0-4 drive the five pixel columns
// - codes with upper nibble zero fetch from the glyph ram
// - a data bit of one lights its pixel, zero leaves it dark
// - set-glyph-address loads address bits 0-5 only, bit 6 kept
// - bit 6 changes by set-text-address, clear, or by step carry or borrow on data reads and writes
// - status read returns busy flag and all seven address bits
// - reset runs a full clear lasting 165 oscillator cycles
// - reset gives increment, no shift, 8-bit bus, one line, normal page, 1:18
// - reset turns display, cursor and blink off
// - reset zeroes both voltage presets, generator off
// - reset returns the serial bus interface to idle
// - reset sets multiplier stages high one, low zero
// - busy while executing; other instructions ignored meanwhile
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module cgm_ctrl #(
  parameter int TEXT_AW = 7
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [6:0] disp_pos_in,
  input wire logic [2:0] disp_row_in,
  input wire logic [4:0] rom_row_in,
  output logic [10:0] rom_addr_out,
  output logic [4:0] pixels_out,
  output logic from_ram_out,
  output logic busy_flag_out,
  output logic display_on_out,
  output logic bus_width_select_out,
  output logic low_mux_select_out,
  output logic multiplier_stage_high_out,
  output logic multiplier_stage_low_out,
  output logic [5:0] vlcd_a_out,
  output logic [5:0] vlcd_b_out,
  output logic bus_if_reset_out
);
  cgm_pkg::cgm_state_t state_reg;
  logic [7:0] cnt_reg;
  logic por_clear_reg;
  logic [6:0] ac_reg;
  logic glyph_mode_reg;
  logic inc_reg, shift_reg, disp_reg, cur_reg, blink_reg;
  logic width_reg, lines_reg, page_reg, mux_reg, sthi_reg, stlo_reg;
  logic [5:0] va_reg, vb_reg;
  logic [7:0] text_reg [2**TEXT_AW];
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;
  logic [7:0] w;
  logic idle, instr_go, data_wr_go, data_rd_go;
  logic is_clear, is_entry, is_disp, is_func, is_gset, is_tset, is_stage, is_vlcd;
  logic [7:0] disp_code;
  logic [6:0] ac_step;
  logic [7:0] clr_len_reg;

  cgm_glyph_if #(.AW(7), .DW(5)) gbus ();

  cgm_glyph_ram #(.AW(7), .DW(5)) u_ram (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .gbus(gbus.ram)
  );

  // request qualification; instruction and data requests need idle, reads of every register still return data while busy
  assign w = reg_wdata_in;
  assign idle = (state_reg == cgm_pkg::ST_IDLE);
  assign instr_go = reg_wr_in && reg_addr_in == cgm_pkg::OFF_INSTR && idle;
  assign data_wr_go = reg_wr_in && reg_addr_in == cgm_pkg::OFF_DATA && idle;
  assign data_rd_go = reg_rd_in && reg_addr_in == cgm_pkg::OFF_DATA && idle;

  // instruction decode, page chosen by the page bit
  assign is_clear = !page_reg && w == 8'h01;
  assign is_entry = !page_reg && w[7:2] == 6'h01;
  assign is_disp = !page_reg && w[7:3] == 5'h01;
  assign is_func = w[7:5] == 3'h1;
  assign is_gset = !page_reg && w[7:6] == 2'h1;
  assign is_tset = !page_reg && w[7];
  assign is_stage = page_reg && w[7:2] == 6'h01 && w[1:0] != 2'h3;
  assign is_vlcd = page_reg && w[7];

  // address step, 7-bit wrap carries into bit 6
  assign ac_step = inc_reg ? ac_reg + 7'h01 : ac_reg - 7'h01;

  // sequencer: clear after reset or clear command, short busy after other commands and data accesses
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= cgm_pkg::ST_CLEAR;
      cnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        cgm_pkg::ST_IDLE: begin
          cnt_reg <= 8'h00;
          if (instr_go && is_clear) begin
            state_reg <= cgm_pkg::ST_CLEAR;
          end else if (instr_go || data_wr_go || data_rd_go) begin
            state_reg <= cgm_pkg::ST_EXEC;
          end
        end
        cgm_pkg::ST_EXEC: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == cgm_pkg::EXEC_CYCLES - 8'h01) begin
            state_reg <= cgm_pkg::ST_IDLE;
          end
        end
        cgm_pkg::ST_CLEAR: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == cgm_pkg::CLEAR_CYCLES - 8'h01) begin
            state_reg <= cgm_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= cgm_pkg::ST_IDLE;
          cnt_reg <= 8'h00;
        end
      endcase
    end
  end

  // reset clear marker, holds serial bus logic in idle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      por_clear_reg <= 1'h1;
    end else if (state_reg == cgm_pkg::ST_CLEAR && cnt_reg == cgm_pkg::CLEAR_CYCLES - 8'h01) begin
      por_clear_reg <= 1'h0;
    end
  end

  // address counter and ram selection
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ac_reg <= 7'h00;
      glyph_mode_reg <= 1'h0;
    end else if (instr_go && is_clear) begin
      ac_reg <= 7'h00;
      glyph_mode_reg <= 1'h0;
    end else if (instr_go && is_gset) begin
      ac_reg <= {ac_reg[6], w[5:0]};
      glyph_mode_reg <= 1'h1;
    end else if (instr_go && is_tset) begin
      ac_reg <= w[6:0];
      glyph_mode_reg <= 1'h0;
    end else if (data_wr_go || data_rd_go) begin
      ac_reg <= ac_step;
    end
  end

  // entry mode and display control
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      inc_reg <= cgm_pkg::RST_INC;
      shift_reg <= cgm_pkg::RST_SHIFT;
      disp_reg <= cgm_pkg::RST_DISP;
      cur_reg <= cgm_pkg::RST_CUR;
      blink_reg <= cgm_pkg::RST_BLINK;
    end else if (instr_go && is_entry) begin
      inc_reg <= w[1];
      shift_reg <= w[0];
    end else if (instr_go && is_disp) begin
      disp_reg <= w[2];
      cur_reg <= w[1];
      blink_reg <= w[0];
    end
  end

  // function set fields
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      width_reg <= cgm_pkg::RST_WIDTH;
      lines_reg <= cgm_pkg::RST_LINES;
      mux_reg <= cgm_pkg::RST_MUX;
      page_reg <= cgm_pkg::RST_PAGE;
    end else if (instr_go && is_func) begin
      width_reg <= w[cgm_pkg::ARG_WIDTH_BIT];
      lines_reg <= w[cgm_pkg::ARG_LINES_BIT];
      mux_reg <= w[cgm_pkg::ARG_MUX_BIT];
      page_reg <= w[cgm_pkg::ARG_PAGE_BIT];
    end
  end

  // multiplier stages and voltage presets
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sthi_reg <= cgm_pkg::RST_STHI;
      stlo_reg <= cgm_pkg::RST_STLO;
      va_reg <= cgm_pkg::RST_VLCD;
      vb_reg <= cgm_pkg::RST_VLCD;
    end else if (instr_go && is_stage) begin
      sthi_reg <= w[1];
      stlo_reg <= w[0];
    end else if (instr_go && is_vlcd && !w[cgm_pkg::ARG_VSEL_BIT]) begin
      va_reg <= w[5:0];
    end else if (instr_go && is_vlcd) begin
      vb_reg <= w[5:0];
    end
  end

  // text code ram: host writes, blank fill during clear
  always_ff @(posedge sys_clk_in) begin
    if (state_reg == cgm_pkg::ST_CLEAR && cnt_reg < 8'(2**TEXT_AW)) begin
      text_reg[cnt_reg[TEXT_AW-1:0]] <= cgm_pkg::TEXT_BLANK;
    end else if (data_wr_go && !glyph_mode_reg) begin
      text_reg[ac_reg[TEXT_AW-1:0]] <= w;
    end
  end

  // glyph ram access through the shared ports
  assign gbus.wr_en = data_wr_go && glyph_mode_reg;
  assign gbus.wr_addr = ac_reg;
  assign gbus.wr_data = w[4:0];
  assign gbus.host_addr = ac_reg;

  // display fetch path
  assign disp_code = text_reg[disp_pos_in[TEXT_AW-1:0]];
  assign rom_addr_out = {disp_code, disp_row_in};

  cgm_row_former u_row (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .disp_en_in(disp_reg),
    .code_in(disp_code),
    .row_in(disp_row_in),
    .cursor_here_in(cur_reg && disp_pos_in == ac_reg && !glyph_mode_reg),
    .ram_data_in(gbus.disp_data),
    .rom_row_in(rom_row_in),
    .ram_addr_out(gbus.disp_addr),
    .pixels_out(pixels_out),
    .from_ram_out(from_ram_out)
  );

  // read data selection
  always_comb begin
    rdata_next = 8'h00;
    case (reg_addr_in)
      cgm_pkg::OFF_DATA: begin
        rdata_next = glyph_mode_reg ? {3'h0, gbus.host_data} : text_reg[ac_reg[TEXT_AW-1:0]];
      end
      cgm_pkg::OFF_STATUS: begin
        rdata_next = {!idle, ac_reg};
      end
      cgm_pkg::OFF_CONFIG: begin
        rdata_next[cgm_pkg::CFG_INC_BIT] = inc_reg;
        rdata_next[cgm_pkg::CFG_SHIFT_BIT] = shift_reg;
        rdata_next[cgm_pkg::CFG_DISP_BIT] = disp_reg;
        rdata_next[cgm_pkg::CFG_CUR_BIT] = cur_reg;
        rdata_next[cgm_pkg::CFG_BLINK_BIT] = blink_reg;
        rdata_next[cgm_pkg::CFG_WIDTH_BIT] = width_reg;
        rdata_next[cgm_pkg::CFG_LINES_BIT] = lines_reg;
        rdata_next[cgm_pkg::CFG_PAGE_BIT] = page_reg;
      end
      cgm_pkg::OFF_MODE: begin
        rdata_next[cgm_pkg::MODE_MUX_BIT] = mux_reg;
        rdata_next[cgm_pkg::MODE_STLO_BIT] = stlo_reg;
        rdata_next[cgm_pkg::MODE_STHI_BIT] = sthi_reg;
        rdata_next[cgm_pkg::MODE_GLYPH_BIT] = glyph_mode_reg;
      end
      cgm_pkg::OFF_VLCD_A: rdata_next = {2'h0, va_reg};
      cgm_pkg::OFF_VLCD_B: rdata_next = {2'h0, vb_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd_in ? rdata_next : 8'h00;
    end
  end

  // outputs
  assign reg_rdata_out = rdata_reg;
  assign busy_flag_out = !idle;
  assign display_on_out = disp_reg;
  assign bus_width_select_out = width_reg;
  assign low_mux_select_out = mux_reg;
  assign multiplier_stage_high_out = sthi_reg;
  assign multiplier_stage_low_out = stlo_reg;
  assign vlcd_a_out = va_reg;
  assign vlcd_b_out = vb_reg;
  assign bus_if_reset_out = por_clear_reg;

  // length of the current clear, checking only
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clr_len_reg <= 8'h00;
    end else if (state_reg == cgm_pkg::ST_CLEAR) begin
      clr_len_reg <= clr_len_reg + 8'h01;
    end else begin
      clr_len_reg <= 8'h00;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  property p_clear_len;
    $fell(state_reg == cgm_pkg::ST_CLEAR) |-> clr_len_reg == cgm_pkg::CLEAR_CYCLES;
  endproperty
  a_clear_len: assert property (p_clear_len) else $error("clear length wrong");

  property p_gset;
    (instr_go && is_gset) |=> ac_reg == {$past(ac_reg[6]), $past(w[5:0])};
  endproperty
  a_gset: assert property (p_gset) else $error("glyph address load wrong");

  property p_tset;
    (instr_go && is_tset) |=> ac_reg == $past(w[6:0]) && !glyph_mode_reg;
  endproperty
  a_tset: assert property (p_tset) else $error("text address load wrong");

  property p_status;
    (reg_rd_in && reg_addr_in == cgm_pkg::OFF_STATUS) |=> reg_rdata_out == {$past(busy_flag_out), $past(ac_reg)};
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");

  property p_busy_ignore;
    (busy_flag_out && reg_wr_in) |=> $stable(ac_reg) && $stable(va_reg) && $stable(disp_reg) && $stable(page_reg);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");

  property p_exec_busy;
    (instr_go && !is_clear) |=> busy_flag_out [*3] ##1 !busy_flag_out;
  endproperty
  a_exec_busy: assert property (p_exec_busy) else $error("command busy time wrong");

  property p_por_busy;
    por_clear_reg |-> busy_flag_out && bus_if_reset_out;
  endproperty
  a_por_busy: assert property (p_por_busy) else $error("not busy during reset clear");

  property p_rst_entry;
    por_clear_reg |-> inc_reg && !shift_reg && width_reg && !lines_reg && !page_reg && !mux_reg;
  endproperty
  a_rst_entry: assert property (p_rst_entry) else $error("reset mode bits wrong");

  property p_rst_disp;
    por_clear_reg |-> !disp_reg && !cur_reg && !blink_reg && pixels_out == 5'h00;
  endproperty
  a_rst_disp: assert property (p_rst_disp) else $error("display not off after reset");

  property p_rst_vlcd;
    por_clear_reg |-> va_reg == 6'h00 && vb_reg == 6'h00;
  endproperty
  a_rst_vlcd: assert property (p_rst_vlcd) else $error("voltage presets not zero");

  property p_rst_stage;
    por_clear_reg |-> sthi_reg && !stlo_reg;
  endproperty
  a_rst_stage: assert property (p_rst_stage) else $error("stage select wrong");

  property p_bus_idle;
    $fell(por_clear_reg) |-> $past(state_reg == cgm_pkg::ST_CLEAR) && !bus_if_reset_out;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("bus reset release wrong");

  c_glyph_write: cover property (data_wr_go && glyph_mode_reg);
  c_carry_b6: cover property (data_wr_go && glyph_mode_reg && ac_reg == 7'h3F && inc_reg);
  c_clear_cmd: cover property (instr_go && is_clear);
  c_ram_glyph: cover property (from_ram_out && display_on_out);
endmodule : cgm_ctrl
`default_nettype wire

// ### logic/cgm_pkg.sv
// constants and types shared by the glyph mapping block
package cgm_pkg;
  // widths
  localparam int unsigned AC_W = 7;
  localparam int unsigned COL_W = 5;
  localparam int unsigned ROW_W = 3;
  localparam int unsigned CODE_W = 8;
  localparam int unsigned VLCD_W = 6;
  // register offsets on the plain register port
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CONFIG = 8'h0C;
  localparam logic [7:0] OFF_MODE = 8'h10;
  localparam logic [7:0] OFF_VLCD_A = 8'h14;
  localparam logic [7:0] OFF_VLCD_B = 8'h18;
  // status, config and mode field positions
  localparam int unsigned STAT_BUSY_BIT = 7;
  localparam int unsigned CFG_INC_BIT = 0;
  localparam int unsigned CFG_SHIFT_BIT = 1;
  localparam int unsigned CFG_DISP_BIT = 2;
  localparam int unsigned CFG_CUR_BIT = 3;
  localparam int unsigned CFG_BLINK_BIT = 4;
  localparam int unsigned CFG_WIDTH_BIT = 5;
  localparam int unsigned CFG_LINES_BIT = 6;
  localparam int unsigned CFG_PAGE_BIT = 7;
  localparam int unsigned MODE_MUX_BIT = 0;
  localparam int unsigned MODE_STLO_BIT = 1;
  localparam int unsigned MODE_STHI_BIT = 2;
  localparam int unsigned MODE_GLYPH_BIT = 3;
  // instruction argument positions
  localparam int unsigned ARG_WIDTH_BIT = 4;
  localparam int unsigned ARG_LINES_BIT = 2;
  localparam int unsigned ARG_MUX_BIT = 1;
  localparam int unsigned ARG_PAGE_BIT = 0;
  localparam int unsigned ARG_VSEL_BIT = 6;
  // reset values
  localparam logic RST_INC = 1'h1;
  localparam logic RST_SHIFT = 1'h0;
  localparam logic RST_DISP = 1'h0;
  localparam logic RST_CUR = 1'h0;
  localparam logic RST_BLINK = 1'h0;
  localparam logic RST_WIDTH = 1'h1;
  localparam logic RST_LINES = 1'h0;
  localparam logic RST_PAGE = 1'h0;
  localparam logic RST_MUX = 1'h0;
  localparam logic RST_STHI = 1'h1;
  localparam logic RST_STLO = 1'h0;
  localparam logic [5:0] RST_VLCD = 6'h00;
  // timing in oscillator cycles, one oscillator cycle per clock
  localparam int unsigned OSC_PER_CLK = 1;
  localparam int unsigned CLEAR_OSC_CYCLES = 165;
  localparam int unsigned EXEC_OSC_CYCLES = 3;
  localparam logic [7:0] CLEAR_CYCLES = 8'(CLEAR_OSC_CYCLES * OSC_PER_CLK);
  localparam logic [7:0] EXEC_CYCLES = 8'(EXEC_OSC_CYCLES * OSC_PER_CLK);
  // fill and row constants
  localparam logic [7:0] TEXT_BLANK = 8'h20;
  localparam logic [2:0] CURSOR_ROW = 3'h7;
  // controller states
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_CLEAR} cgm_state_t;
endpackage : cgm_pkg

// ### logic/cgm_glyph_if.sv
// ports between the controller and the user glyph ram
`timescale 1ns/100ps
`default_nettype none
interface cgm_glyph_if #(parameter int AW = 7, parameter int DW = 5);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] host_addr;
  logic [DW-1:0] host_data;
  logic [AW-1:0] disp_addr;
  logic [DW-1:0] disp_data;
  modport ram (input wr_en, input wr_addr, input wr_data, input host_addr, input disp_addr,
    output host_data, output disp_data);
  modport user (output wr_en, output wr_addr, output wr_data, output host_addr, output disp_addr,
    input host_data, input disp_data);
endinterface : cgm_glyph_if
`default_nettype wire

// ### logic/cgm_glyph_ram.sv
// user glyph ram: flip-flop storage, one write and two read ports
`timescale 1ns/100ps
`default_nettype none
module cgm_glyph_ram #(
  parameter int AW = 7,
  parameter int DW = 5
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  cgm_glyph_if.ram gbus
);
  logic [DW-1:0] mem_reg [2**AW];

  // pattern rows written by the host
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (gbus.wr_en) begin
      mem_reg[gbus.wr_addr] <= gbus.wr_data;
    end
  end

  // read ports
  assign gbus.host_data = mem_reg[gbus.host_addr];
  assign gbus.disp_data = mem_reg[gbus.disp_addr];
endmodule : cgm_glyph_ram
`default_nettype wire

// ### logic/cgm_row_former.sv
// builds one pixel row of a character cell
`timescale 1ns/100ps
`default_nettype none
module cgm_row_former (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic disp_en_in,
  input wire logic [7:0] code_in,
  input wire logic [2:0] row_in,
  input wire logic cursor_here_in,
  input wire logic [4:0] ram_data_in,
  input wire logic [4:0] rom_row_in,
  output logic [6:0] ram_addr_out,
  output logic [4:0] pixels_out,
  output logic from_ram_out
);
  logic use_ram;
  logic [4:0] row_bits;

  // glyph select from code low nibble, row from the row index
  assign ram_addr_out = {code_in[3:0], row_in};
  assign use_ram = (code_in[7:4] == 4'h0);
  assign row_bits = use_ram ? ram_data_in : rom_row_in;

  // one bit per column, set bit lights the pixel; cursor ored on last row
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pixels_out <= 5'h00;
      from_ram_out <= 1'h0;
    end else begin
      from_ram_out <= use_ram;
      if (!disp_en_in) begin
        pixels_out <= 5'h00;
      end else if (row_in == cgm_pkg::CURSOR_ROW && cursor_here_in) begin
        pixels_out <= row_bits | 5'h1F;
      end else begin
        pixels_out <= row_bits;
      end
    end
  end

  property p_ram_pick;
    @(posedge sys_clk_in) disable iff (rst_in)
    (disp_en_in && code_in[7:4] == 4'h0 && !cursor_here_in) |=> (pixels_out == $past(ram_data_in)) && from_ram_out;
  endproperty
  a_ram_pick: assert property (p_ram_pick) else $error("ram glyph row not shown");

  property p_cursor_or;
    @(posedge sys_clk_in) disable iff (rst_in)
    (disp_en_in && row_in == cgm_pkg::CURSOR_ROW && cursor_here_in) |=> pixels_out == 5'h1F;
  endproperty
  a_cursor_or: assert property (p_cursor_or) else $error("cursor row not ored");

  property p_rom_pick;
    @(posedge sys_clk_in) disable iff (rst_in)
    (disp_en_in && code_in[7:4] != 4'h0 && row_in != cgm_pkg::CURSOR_ROW) |=> pixels_out == $past(rom_row_in);
  endproperty
  a_rom_pick: assert property (p_rom_pick) else $error("rom row not shown");
endmodule : cgm_row_former
`default_nettype wire

// ### bench/cgm_host_model.sv
// host side model: register port master for the glyph mapping block
`timescale 1ns/100ps
`default_nettype none
module cgm_host_model (
  input wire logic sys_clk_in,
  input wire logic busy_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  // idle bus at time zero
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one write strobe on the next edge, no busy check
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge sys_clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d; // released data shows garbage
  endtask : put
  // write, then poll busy until the command has run
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    repeat ($urandom % 2) @(posedge sys_clk_in); // sometimes late
    put(a, d);
    for (n = 0; n < 400; n++) begin
      @(posedge sys_clk_in);
      #1;
      if (busy_in === 1'b0) break;
    end
    if (n == 400) begin
      tb.bad_count++;
      tb.complete_run();
    end
  endtask : wr
  // one read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge sys_clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge sys_clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    q = rdata_in;
  endtask : rd
endmodule : cgm_host_model
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the glyph mapping controller
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [7:0] A_INS = cgm_pkg::OFF_INSTR;
  localparam logic [7:0] A_DAT = cgm_pkg::OFF_DATA;
  localparam logic [7:0] A_CFG = cgm_pkg::OFF_CONFIG;
  localparam logic [7:0] A_MOD = cgm_pkg::OFF_MODE;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] ra, wd, rdata, q;
  logic wr, rd, busy, from_ram, d_on, bw, mx, sh, sl, if_rst;
  logic [6:0] dpos = 7'h00;
  logic [2:0] drow = 3'h0;
  logic [4:0] rom_row, pix;
  logic [10:0] rom_addr;
  logic [5:0] va, vb;
  int bad_count = 0;
  int cmp_count = 0;
  int exp_ram [128];
  // clock and stand-in fixed glyph rom
  always #12.5 sys_clk_in = ~sys_clk_in;
  assign rom_row = rom_addr[4:0] ^ rom_addr[9:5];
  cgm_ctrl uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .disp_pos_in(dpos), .disp_row_in(drow),
    .rom_row_in(rom_row), .rom_addr_out(rom_addr), .pixels_out(pix), .from_ram_out(from_ram),
    .busy_flag_out(busy), .display_on_out(d_on), .bus_width_select_out(bw), .low_mux_select_out(mx),
    .multiplier_stage_high_out(sh), .multiplier_stage_low_out(sl), .vlcd_a_out(va), .vlcd_b_out(vb),
    .bus_if_reset_out(if_rst));
  cgm_host_model host (.sys_clk_in(sys_clk_in), .busy_in(busy), .rdata_in(rdata), .addr_out(ra),
    .wdata_out(wd), .wr_out(wr), .rd_out(rd));
  // verdict and end of run
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // value compare
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // register read compare
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e, input string what);
    host.rd(a, q);
    chk(what, e, q);
  endtask : chk_reg
  // pixel row compare, one cycle after position and row
  task automatic show(input logic [6:0] p, input logic [2:0] r, input logic [4:0] e, input logic src);
    @(posedge sys_clk_in);
    dpos <= p;
    drow <= r;
    @(posedge sys_clk_in);
    #1;
    chk("pixels", {3'h0, e}, {3'h0, pix});
    chk("from_ram", {7'h0, src}, {7'h0, from_ram});
  endtask : show
  // model of the fixed rom row for a code and row
  function automatic logic [4:0] rom_exp(input int code, input int r);
    int a;
    a = code * 8 + r;
    return 5'((a ^ (a >> 5)) & 31);
  endfunction : rom_exp
  // reset, then measure the clear
  task automatic do_reset();
    int n;
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (12) @(posedge sys_clk_in);
    chk("busy_rst", 8'h01, {7'h0, busy});
    chk("if_rst", 8'h01, {7'h0, if_rst});
    rst_in <= 1'b0;
    #1;
    for (n = 0; n < 400 && busy === 1'b1; n++) begin
      @(posedge sys_clk_in);
      #1;
    end
    chk("clear_len", 8'hA5, 8'(n));
    chk("if_rst_end", 8'h00, {7'h0, if_rst});
    if (n == 400) complete_run();
    chk_reg(A_CFG, 8'(1 << cgm_pkg::CFG_INC_BIT) | 8'(1 << cgm_pkg::CFG_WIDTH_BIT), "cfg");
    chk_reg(A_MOD, 8'(1 << cgm_pkg::MODE_STHI_BIT), "mode");
    chk_reg(cgm_pkg::OFF_VLCD_A, 8'h00, "vlcd_a");
    chk_reg(cgm_pkg::OFF_VLCD_B, 8'h00, "vlcd_b");
    chk_reg(cgm_pkg::OFF_STATUS, 8'h00, "status");
    chk_reg(8'h1C, 8'h00, "unmapped");
    chk("pins", 8'h0A, {3'h0, d_on, bw, mx, sh, sl});
    chk("vlcd_pins", 8'h00, {2'h0, va | vb});
  endtask : do_reset
  // main sequence
  initial begin
    int c, base, p, rc;
    void'($urandom(13348));
    do_reset();
    host.put(A_INS, 8'h90);
    host.put(A_INS, 8'h0F);
    chk_reg(A_CFG, 8'h21, "cfg_refused");
    chk_reg(cgm_pkg::OFF_STATUS, 8'h10, "ac_text");
    host.wr(A_INS, 8'hC0);
    host.wr(A_INS, 8'h45);
    chk_reg(cgm_pkg::OFF_STATUS, 8'h45, "ac_bit6_kept");
    host.wr(A_INS, 8'h0C);
    for (int k = 0; k < 2; k++) begin
      c = (k == 0) ? 7 : $urandom % 16;
      rc = (k == 0) ? 8'h10 : 8'hF7;
      base = c * 8;
      p = 3 + k * 8;
      host.wr(A_INS, 8'(128 | base));
      host.wr(A_INS, 8'(64 | (base & 63)));
      for (int r = 0; r < 8; r++) begin
        exp_ram[base + r] = $urandom % 256;
        host.wr(A_DAT, 8'(exp_ram[base + r]));
        exp_ram[base + r] = exp_ram[base + r] & 31;
      end
      chk_reg(cgm_pkg::OFF_STATUS, 8'((base + 8) % 128), "ac_fill");
      host.wr(A_INS, 8'(128 | base));
      host.wr(A_INS, 8'(64 | (base & 63)));
      chk_reg(A_DAT, 8'(exp_ram[base]), "glyph_read");
      repeat (3) @(posedge sys_clk_in);
      host.wr(A_INS, 8'(128 | p));
      host.wr(A_DAT, 8'(c));
      host.wr(A_DAT, 8'(rc));
      for (int r = 0; r < 8; r++) begin
        show(7'(p), 3'(r), 5'(exp_ram[base + r]), 1'b1);
        show(7'(p + 1), 3'(r), rom_exp(rc, r), 1'b0);
      end
    end
    host.wr(A_INS, 8'h0E);
    host.wr(A_INS, 8'(128 | p));
    show(7'(p), 3'h7, 5'h1F, 1'b1);
    show(7'(p), 3'h6, 5'(exp_ram[base + 6]), 1'b1);
    host.wr(A_INS, 8'h01);
    chk_reg(cgm_pkg::OFF_STATUS, 8'h00, "ac_clear");
    show(7'(p), 3'h2, rom_exp(cgm_pkg::TEXT_BLANK, 2), 1'b0);
    host.wr(A_INS, 8'h04);
    host.wr(A_DAT, 8'h41);
    chk_reg(cgm_pkg::OFF_STATUS, 8'h7F, "ac_dec");
    host.wr(A_INS, 8'h31);
    host.wr(A_INS, 8'h95);
    host.wr(A_INS, 8'hEA);
    host.wr(A_INS, 8'h05);
    chk_reg(cgm_pkg::OFF_VLCD_A, 8'h15, "vlcd_a_set");
    chk_reg(cgm_pkg::OFF_VLCD_B, 8'h2A, "vlcd_b_set");
    chk_reg(A_MOD, 8'(1 << cgm_pkg::MODE_STLO_BIT), "mode_stage");
    do_reset();
    complete_run();
  end
endmodule : tb
`default_nettype wire
